// [rtl/atu_core.sv]
// address trap unit: fetch watch, trap nmi or reset, apb registers
`timescale 1ns/1ps
module atu_core
  import atu_pkg::*;
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   ce,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   fetch_valid,
  input  wire logic [ATU_AW-1:0]      fetch_addr,
  output logic                        fetch_abort,
  input  wire logic                   irq_master_flag,
  input  wire logic                   maskable_irq_req,
  output logic                        cpu_irq_take,
  output logic                        addr_trap_irq,
  input  wire logic                   nmi_ack,
  input  wire logic                   nmi_return_instr,
  input  wire logic                   low_speed_mode_one,
  output logic                        int_reset_n,
  output logic                        hf_osc_restart,
  output logic                        irq
);
  atu_trap_if t ();

  logic                   sel_q;
  logic                   ram_stage_q;
  logic                   ram_act_q;
  logic [ATU_ST_W-1:0]    stat_q;
  logic [ATU_ST_W-1:0]    mask_q;
  logic                   nmi_q;
  logic [ATU_DEPTH_W-1:0] depth_q;
  logic [31:0]            prdata_q;
  logic                   wr;
  logic                   rd;
  logic                   mapped;
  logic                   trap_irq_ev;
  logic                   trap_rst_ev;
  logic                   hw_rst;
  logic [ATU_ST_W-1:0]    stat_set;
  logic [ATU_ST_W-1:0]    stat_clr;

  assign t.fetch_valid = fetch_valid;
  assign t.fetch_addr  = fetch_addr;
  assign t.ram_trap_en = ram_act_q;
  assign t.slow_mode   = low_speed_mode_one;

  atu_fetch_cmp u_cmp (
    .t (t)
  );

  atu_rst_timer u_rst (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .t       (t)
  );

  // trap events, checked in the fetch cycle
  assign trap_irq_ev = ce && t.hit && !sel_q;
  assign trap_rst_ev = ce && t.hit && sel_q;
  assign t.rst_req   = trap_rst_ev;
  assign hw_rst      = t.rst_busy;
  // blocks the trapping opcode from executing
  assign fetch_abort = t.hit;

  // apb decode, zero wait states
  assign wr     = psel && penable && pwrite && ce;
  assign rd     = psel && !penable && !pwrite;
  assign mapped = (paddr == ATU_OFS_CTRL) || (paddr == ATU_OFS_CODE) ||
                  (paddr == ATU_OFS_STAT) || (paddr == ATU_OFS_MASK) ||
                  (paddr == ATU_OFS_DEPTH);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // control: select and staged ram trap bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_q       <= ATU_SEL_RST;
      ram_stage_q <= ATU_RAMT_RST;
    end
    else if (ce)
    begin
      if (hw_rst)
      begin
        sel_q       <= ATU_SEL_RST;
        ram_stage_q <= ATU_RAMT_RST;
      end
      else if (wr && paddr == ATU_OFS_CTRL)
      begin
        sel_q       <= pwdata[ATU_CTRL_SEL];
        ram_stage_q <= pwdata[ATU_CTRL_RAMS];
      end
    end
  end

  // staged bit takes effect only on the enable code
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ram_act_q <= ATU_RAMT_RST;
    else if (ce)
    begin
      if (hw_rst)
        ram_act_q <= ATU_RAMT_RST;
      else if (wr && paddr == ATU_OFS_CODE &&
               pwdata[7:0] == ATU_CODE_APPLY)
        ram_act_q <= ram_stage_q;
    end
  end

  // sticky status, set wins over write-one clear
  assign stat_set = {trap_rst_ev, trap_irq_ev};
  assign stat_clr = (wr && paddr == ATU_OFS_STAT) ?
                    pwdata[ATU_ST_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stat_q <= '0;
    else if (ce)
      stat_q <= (stat_q & ~stat_clr) | stat_set;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask_q <= ATU_MASK_RST;
    else if (ce && wr && paddr == ATU_OFS_MASK)
      mask_q <= pwdata[ATU_ST_W-1:0];
  end

  assign irq = |(stat_q & mask_q);

  // nmi request held until the cpu takes it or a trap reset clears it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      nmi_q <= 1'b0;
    else if (ce)
    begin
      if (hw_rst)
        nmi_q <= 1'b0;
      else if (trap_irq_ev)
        nmi_q <= 1'b1;
      else if (nmi_ack)
        nmi_q <= 1'b0;
    end
  end

  // trap is raised even while a service runs, nesting deeper
  assign addr_trap_irq = nmi_q;
  // non-maskable: not gated by the master flag
  assign cpu_irq_take  = nmi_q || (irq_master_flag && maskable_irq_req);

  // nesting depth of accepted traps, for software visibility
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      depth_q <= '0;
    else if (ce)
    begin
      if (hw_rst)
        depth_q <= '0;
      else if (nmi_q && nmi_ack && !nmi_return_instr &&
               depth_q != '1)
        depth_q <= depth_q + 1'b1;
      else if (nmi_return_instr && !(nmi_q && nmi_ack) &&
               depth_q != '0)
        depth_q <= depth_q - 1'b1;
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0000_0000;
    else if (ce && rd)
    begin
      unique case (paddr)
        ATU_OFS_CTRL:
          prdata_q <= {29'h0, ram_act_q, ram_stage_q, sel_q};
        ATU_OFS_STAT:
          prdata_q <= {30'h0, stat_q};
        ATU_OFS_MASK:
          prdata_q <= {30'h0, mask_q};
        ATU_OFS_DEPTH:
          prdata_q <= {28'h0, depth_q};
        default:
          prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata = prdata_q;

  // internal reset and oscillator restart to the rest of the chip
  assign int_reset_n    = !hw_rst;
  assign hf_osc_restart = t.osc_restart;
endmodule : atu_core

// [rtl/atu_fetch_cmp.sv]
// opcode fetch address range compare
`timescale 1ns/1ps
module atu_fetch_cmp
  import atu_pkg::*;
(
  atu_trap_if.cmp t
);
  logic in_sfr;
  logic in_ram;

  assign in_sfr = (t.fetch_addr >= ATU_SFR_LO) && (t.fetch_addr <= ATU_SFR_HI);
  assign in_ram = (t.fetch_addr >= ATU_RAM_LO) && (t.fetch_addr <= ATU_RAM_HI);
  // sfr always traps, ram only when enabled
  assign t.hit  = t.fetch_valid && (in_sfr || (in_ram && t.ram_trap_en));
endmodule : atu_fetch_cmp

// [rtl/atu_pkg.sv]
// constants and types for the address trap unit
package atu_pkg;
  localparam int unsigned ATU_AW         = 16;
  // register byte offsets
  localparam logic [7:0]  ATU_OFS_CTRL   = 8'h00;
  localparam logic [7:0]  ATU_OFS_CODE   = 8'h04;
  localparam logic [7:0]  ATU_OFS_STAT   = 8'h08;
  localparam logic [7:0]  ATU_OFS_MASK   = 8'h0c;
  localparam logic [7:0]  ATU_OFS_DEPTH  = 8'h10;
  // control field positions
  localparam int unsigned ATU_CTRL_SEL   = 0;
  localparam int unsigned ATU_CTRL_RAMS  = 1;
  localparam int unsigned ATU_CTRL_RAMA  = 2;
  // status / mask field positions
  localparam int unsigned ATU_ST_IRQ     = 0;
  localparam int unsigned ATU_ST_RST     = 1;
  localparam int unsigned ATU_ST_W       = 2;
  // enable code for the staged ram trap bit
  localparam logic [7:0]  ATU_CODE_APPLY = 8'hd2;
  // reset values
  localparam logic        ATU_SEL_RST    = 1'b0;
  localparam logic        ATU_RAMT_RST   = 1'b0;
  localparam logic [1:0]  ATU_MASK_RST   = 2'h0;
  // address ranges, inclusive
  localparam logic [15:0] ATU_SFR_LO     = 16'h0000;
  localparam logic [15:0] ATU_SFR_HI     = 16'h003f;
  localparam logic [15:0] ATU_RAM_LO     = 16'h0040;
  localparam logic [15:0] ATU_RAM_HI     = 16'h013f;
  // internal reset length, high-frequency clock periods
  localparam int unsigned ATU_RST_FC_PER = 24;
  localparam int unsigned ATU_FC_HZ      = 40_000_000;
  localparam int unsigned ATU_PCLK_HZ    = 40_000_000;
  // longest time rounds down, never below one cycle
  localparam int unsigned ATU_RST_CYC_RAW =
    (ATU_RST_FC_PER * (ATU_PCLK_HZ / 1000)) / (ATU_FC_HZ / 1000);
  localparam int unsigned ATU_RST_CYC =
    (ATU_RST_CYC_RAW < 1) ? 1 : ATU_RST_CYC_RAW;
  localparam int unsigned ATU_DEPTH_W    = 4;
  typedef enum logic {ATU_RS_IDLE, ATU_RS_HOLD} atu_rst_state_e;
endpackage : atu_pkg

// [rtl/atu_rst_timer.sv]
// stretches a trap reset request to a fixed number of cycles
`timescale 1ns/1ps
module atu_rst_timer
  import atu_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  atu_trap_if.timer t
);
  localparam logic [7:0] LAST = 8'(ATU_RST_CYC - 1);

  atu_rst_state_e state_q;
  logic [7:0]     cnt_q;
  logic           osc_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ATU_RS_IDLE;
      cnt_q   <= 8'h00;
    end
    else if (ce)
    begin
      unique case (state_q)
        ATU_RS_IDLE:
        begin
          if (t.rst_req)
          begin
            state_q <= ATU_RS_HOLD;
            cnt_q   <= 8'h00;
          end
        end
        ATU_RS_HOLD:
        begin
          if (cnt_q == LAST)
            state_q <= ATU_RS_IDLE;
          else
            cnt_q <= cnt_q + 8'h01;
        end
      endcase
    end
  end

  // oscillator restart pulse when reset starts in slow mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      osc_q <= 1'b0;
    else if (ce)
      osc_q <= (state_q == ATU_RS_IDLE) && t.rst_req && t.slow_mode;
  end

  assign t.rst_busy    = (state_q == ATU_RS_HOLD);
  assign t.osc_restart = osc_q;
endmodule : atu_rst_timer

// [rtl/atu_trap_if.sv]
// trap detect and reset stretch signals between unit parts
`timescale 1ns/1ps
interface atu_trap_if;
  logic        fetch_valid;
  logic [15:0] fetch_addr;
  logic        ram_trap_en;
  logic        hit;
  logic        rst_req;
  logic        slow_mode;
  logic        rst_busy;
  logic        osc_restart;
  modport cmp   (input fetch_valid, fetch_addr, ram_trap_en, output hit);
  modport timer (input rst_req, slow_mode, output rst_busy, osc_restart);
  modport core  (output fetch_valid, fetch_addr, ram_trap_en, rst_req,
                 slow_mode,
                 input hit, rst_busy, osc_restart);
endinterface : atu_trap_if

// [testbench/atu_core_monitor.sv]
// port assertions for the address trap unit
`timescale 1ns/1ps
module atu_core_monitor
  import atu_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  input wire logic        fetch_valid,
  input wire logic [15:0] fetch_addr,
  input wire logic        fetch_abort,
  input wire logic        addr_trap_irq,
  input wire logic        cpu_irq_take,
  input wire logic        nmi_ack,
  input wire logic        int_reset_n,
  input wire logic        hf_osc_restart,
  input wire logic        low_speed_mode_one
);
  logic [5:0] low_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // cycles spent in the internal reset
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      low_q <= 6'h0;
    else if (ce)
      low_q <= int_reset_n ? 6'h0 : low_q + 6'h1;
  sfr_trap_a: assert property (
    fetch_valid && fetch_addr <= ATU_SFR_HI |-> fetch_abort)
    else $error("sfr fetch missed");
  trap_act_a: assert property (
    ce && int_reset_n && fetch_valid && fetch_abort
    |=> addr_trap_irq || !int_reset_n) else $error("trap lost");
  nmi_pass_a: assert property (addr_trap_irq |-> cpu_irq_take)
    else $error("nmi blocked");
  irq_cause_a: assert property (
    $rose(addr_trap_irq) |-> $past(fetch_valid && fetch_abort))
    else $error("irq without trap");
  irq_hold_a: assert property (
    addr_trap_irq && !nmi_ack && int_reset_n
    |=> addr_trap_irq || !int_reset_n) else $error("irq dropped");
  rst_len_a: assert property (
    $rose(int_reset_n) |-> low_q == ATU_RST_CYC) else $error("reset len");
  osc_rst_a: assert property (
    $fell(int_reset_n) |-> hf_osc_restart == $past(low_speed_mode_one))
    else $error("osc restart");
  rst_clr_a: assert property (
    $fell(int_reset_n) |=> !addr_trap_irq) else $error("nmi kept");
endmodule : atu_core_monitor
bind atu_core atu_core_monitor atu_core_monitor_i (.pclk, .presetn, .ce,
  .fetch_valid, .fetch_addr, .fetch_abort, .addr_trap_irq, .cpu_irq_take,
  .nmi_ack, .int_reset_n, .hf_osc_restart, .low_speed_mode_one);

// [testbench/atu_core_tb.sv]
// testbench for the address trap unit
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module atu_core_tb
  import atu_pkg::*;
;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, go = 1'b0, nmi_return_instr = 1'b0;
  logic        irq_master_flag = 1'b0, maskable_irq_req = 1'b0, ce = 1'b1;
  logic        low_speed_mode_one = 1'b0, er;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic [15:0] go_addr = 16'h0, fetch_addr;
  logic [3:0]  ack_lat = 4'h0;
  logic        pready, pslverr, fetch_valid, fetch_abort, cpu_irq_take;
  logic        addr_trap_irq, nmi_ack, int_reset_n, hf_osc_restart, irq;
  int          n_fail = 0, tests_run = 0, n_low = 0, n_osc = 0;
  always #12.5 pclk = ~pclk;
  always @(negedge pclk)
  begin
    if (int_reset_n === 1'b0)
      n_low++;
    if (hf_osc_restart === 1'b1)
      n_osc++;
  end
  atu_core atu_core_i (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .fetch_valid, .fetch_addr,
    .fetch_abort, .irq_master_flag, .maskable_irq_req, .cpu_irq_take,
    .addr_trap_irq, .nmi_ack, .nmi_return_instr, .low_speed_mode_one,
    .int_reset_n, .hf_osc_restart, .irq);
  atu_cpu_model atu_cpu_model_i (.pclk, .presetn, .go, .go_addr, .ack_lat,
    .addr_trap_irq, .int_reset_n, .fetch_valid, .fetch_addr, .nmi_ack);
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : rdc
  // one opcode fetch, then settle to a falling edge
  task automatic fetch(input logic [15:0] a);
    @(posedge pclk);
    go      <= 1'b1;
    go_addr <= a;
    @(posedge pclk);
    go      <= 1'b0;
    repeat (4) @(posedge pclk);
    @(negedge pclk);
  endtask : fetch
  task automatic conclude;
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdc(ATU_OFS_CTRL, 32'h0);
    rdc(ATU_OFS_DEPTH, 32'h0);
    `CHK(er, 1'b0)
    rdc(8'h14, 32'h0);
    `CHK(er, 1'b1)
    for (int i = 3; i >= 0; i--)
    begin
      @(posedge pclk);
      {irq_master_flag, maskable_irq_req} <= 2'(i);
      @(negedge pclk);
      `CHK(cpu_irq_take, i == 3)
    end
    $display("test reset values done");
    apb(1'b1, ATU_OFS_MASK, 32'h3);
    ack_lat <= 4'hf;
    fetch(ATU_SFR_HI);
    `CHK({addr_trap_irq, cpu_irq_take, irq}, 3'b111)
    rdc(ATU_OFS_STAT, 32'h1);
    apb(1'b1, ATU_OFS_STAT, 32'h1);
    rdc(ATU_OFS_STAT, 32'h0);
    ack_lat <= 4'h0;
    repeat (12) @(posedge pclk);
    rdc(ATU_OFS_DEPTH, 32'h1);
    $display("test sfr trap done");
    fetch(ATU_RAM_LO);
    apb(1'b1, ATU_OFS_CTRL, 32'h2);
    fetch(ATU_RAM_LO);
    rdc(ATU_OFS_STAT, 32'h0);
    apb(1'b1, ATU_OFS_CODE, {24'h0, ATU_CODE_APPLY});
    rdc(ATU_OFS_CTRL, 32'h6);
    apb(1'b1, ATU_OFS_MASK, 32'h0);
    fetch(ATU_RAM_HI + 16'h1);
    rdc(ATU_OFS_STAT, 32'h0);
    fetch(ATU_RAM_HI);
    `CHK(irq, 1'b0)
    rdc(ATU_OFS_STAT, 32'h1);
    $display("test ram trap done");
    fetch(ATU_SFR_LO);
    fetch(ATU_SFR_LO);
    rdc(ATU_OFS_DEPTH, 32'h4);
    nmi_return_instr <= 1'b1;
    @(posedge pclk);
    nmi_return_instr <= 1'b0;
    rdc(ATU_OFS_DEPTH, 32'h3);
    // a trapping fetch while frozen must leave no trace
    ce <= 1'b0;
    fetch(ATU_SFR_LO);
    @(posedge pclk);
    ce <= 1'b1;
    rdc(ATU_OFS_DEPTH, 32'h3);
    $display("test nesting done");
    apb(1'b1, ATU_OFS_STAT, 32'h3);
    apb(1'b1, ATU_OFS_MASK, 32'h3);
    low_speed_mode_one <= 1'b1;
    ack_lat <= 4'hf;
    // trap interrupt still pending when the reset trap hits
    fetch(ATU_SFR_LO);
    `CHK(addr_trap_irq, 1'b1)
    apb(1'b1, ATU_OFS_CTRL, 32'h1);
    fetch(ATU_SFR_LO);
    repeat (30) @(posedge pclk);
    `CHK(n_low, 24)
    `CHK(n_osc, 1)
    `CHK(addr_trap_irq, 1'b0)
    rdc(ATU_OFS_CTRL, 32'h0);
    rdc(ATU_OFS_DEPTH, 32'h0);
    rdc(ATU_OFS_STAT, 32'h3);
    `CHK(irq, 1'b1)
    $display("test trap reset done");
    conclude();
  end
  initial
  begin
    #20us;
    n_fail++;
    conclude();
  end
endmodule : atu_core_tb

// [testbench/atu_cpu_model.sv]
// cpu side model: opcode fetches and trap acknowledge
`timescale 1ns/1ps
module atu_cpu_model
  import atu_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        go,
  input  wire logic [15:0] go_addr,
  input  wire logic [3:0]  ack_lat,
  input  wire logic        addr_trap_irq,
  input  wire logic        int_reset_n,
  output logic             fetch_valid,
  output logic [15:0]      fetch_addr,
  output logic             nmi_ack
);
  logic [3:0] wait_q;
  logic       pend;
  assign pend = addr_trap_irq && !nmi_ack;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      fetch_valid <= 1'b0;
      fetch_addr  <= 16'h0000;
      nmi_ack     <= 1'b0;
      wait_q      <= 4'h0;
    end
    else
    begin
      fetch_valid <= go && int_reset_n;
      // idle address keeps moving while no fetch is valid
      fetch_addr  <= go ? go_addr : ~fetch_addr;
      nmi_ack     <= pend && wait_q == ack_lat;
      wait_q      <= (pend && wait_q != ack_lat) ? wait_q + 4'h1 : 4'h0;
    end
endmodule : atu_cpu_model
